//--- logic/prt_top.sv
// relay trip, reset, fault-memory clear and output test logic with AXI4-Lite registers
// Operation
// - immediate fast trip: trip when any phase current can power the relay
// - after-pickup fast trip: trip only while current exceeds pickup threshold
// - blocking input suppresses each element whose block bit is set; ef_alarm still fires while blocked
// - reset-mode bit selects automatic or manual clearing of LED and relay 1
// - manual: display on, select held 3 s clears message, LED, relay 1
// - current-powered auto reset thresholds 0.35/0.22/0.17 A for 1/2/3 phases
// - with aux supply auto reset needs phase >5% and earth >2% of In
// - auto reset acts only 3 s after a trip
// - auto mode and current-powered: show date and time, not fault memory
// - external reset clears relay and LED, message held while active
// - serial software reset acts exactly as manual reset
// - minus and select held 3 s erase the fault memory
// - test entry only on battery, no current, correct password
// - no test current within 30 s: leave test, show settings message
// - test starts at 1 A test current and shows running message
// - protection inhibited throughout the relay test
// - pulse output, alarm and flags for 150 ms together; alarm stays on
// - pause 1 s, self-test relay 1 s, pause 1 s, then blink and prompt
// - select press drops alarm and self-test relays, LED off, prompt removal
// - test current too low for the coil aborts test with stopped message
// - overcurrent and high set stage share the trip; first one trips
// - only the fundamental from the fourier_filter is evaluated
// - alarm-only ground_fault_stage fires neither latch nor LED
// - trip-LED bit selects flashing or inactive indicator
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module prt_top
    import prt_pkg::*;
#(
    parameter int unsigned    DIV  = CYC_MS,
    parameter logic [TW-1:0]  HOLD = HOLD_T,
    parameter logic [TW-1:0]  WAIT = WAIT_T
) (
    input  wire logic        aclk,          // 50 MHz clock
    input  wire logic        aresetn,       // sync reset, low
    input  wire logic        s_axi_awvalid, // write address valid
    output logic             s_axi_awready, // write address ready
    input  wire logic [7:0]  s_axi_awaddr,  // write byte address
    input  wire logic        s_axi_wvalid,  // write data valid
    output logic             s_axi_wready,  // write data ready
    input  wire logic [31:0] s_axi_wdata,   // write data
    input  wire logic [3:0]  s_axi_wstrb,   // byte enables
    output logic             s_axi_bvalid,  // write response valid
    input  wire logic        s_axi_bready,  // write response ready
    output logic [1:0]       s_axi_bresp,   // write response
    input  wire logic        s_axi_arvalid, // read address valid
    output logic             s_axi_arready, // read address ready
    input  wire logic [7:0]  s_axi_araddr,  // read byte address
    output logic             s_axi_rvalid,  // read data valid
    input  wire logic        s_axi_rready,  // read data ready
    output logic [31:0]      s_axi_rdata,   // read data
    output logic [1:0]       s_axi_rresp,   // read response
    input  wire logic [15:0] ph1_ma,        // phase 1 fundamental, mA
    input  wire logic [15:0] ph2_ma,        // phase 2 fundamental, mA
    input  wire logic [15:0] ph3_ma,        // phase 3 fundamental, mA
    input  wire logic [15:0] earth_ma,      // earth fundamental, mA
    input  wire logic        aux_supply,    // auxiliary supply present
    input  wire logic        fast_trip_in,  // fast-trip input energized
    input  wire logic        block_in,      // blocking input energized
    input  wire logic        ext_reset_in,  // external reset voltage
    input  wire logic        oc_timeout,    // overcurrent_delay expired
    input  wire logic        sc_timeout,    // high set stage expired
    input  wire logic        ef_timeout,    // ground_fault_stage expired
    input  wire logic        efh_timeout,   // ground_high_current_stage expired
    input  wire logic        display_on,    // display active
    input  wire logic        key_select,    // select/reset key
    input  wire logic        key_minus,     // minus key
    output logic             trip_pulse,    // pulse trip output
    output logic             relay1,        // latched output relay 1
    output logic             trip_led,      // trip LED drive
    output logic             alarm_relay,   // alarm relay
    output logic             flag_ind,      // flag indicators
    output logic             selftest_relay,// self-test relay
    output logic             ef_alarm,      // alarm-only earth event
    output logic             prot_inhibit,  // protection inhibited
    output logic             fault_clear,   // fault memory erase pulse
    output prt_msg_t         msg            // display message
);
    logic          tick;
    logic          man_done;
    logic          fm_done;
    logic [7:0]    ctrl;
    logic [15:0]   pickup;
    logic          test_req;
    logic          sw_rst;
    logic          led_on;
    logic [TW-1:0] ms_cnt;
    logic [TW-1:0] since;
    logic [TW-1:0] tcnt;
    prt_test_t     tst;
    prt_test_t     next_tst;
    logic          aw_hold;
    logic          w_hold;
    logic [7:0]    aw_addr;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          wr_do;
    logic          cur_pwr;
    logic          reset_ok;
    logic          over_pick;
    logic          no_cur;
    logic          test_cur;
    logic          trip_req;
    logic          clear;
    logic          auto_rst;
    logic [1:0]    n_pwr2;

    prt_tick #(.DIV(DIV)) u_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (tick)
    );
    prt_hold #(.HOLD(HOLD)) u_man (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (tick),
        .cond    (display_on && key_select && !key_minus),
        .done    (man_done)
    );
    prt_hold #(.HOLD(HOLD)) u_fmem (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (tick),
        .cond    (key_select && key_minus),
        .done    (fm_done)
    );

    // inputs are fundamental magnitudes from the fourier_filter
    always_comb
    begin
        n_pwr2 = 2'(ph1_ma >= PWR2_MA) + 2'(ph2_ma >= PWR2_MA) + 2'(ph3_ma >= PWR2_MA);
        cur_pwr = (ph1_ma >= PWR1_MA) || (ph2_ma >= PWR1_MA) || (ph3_ma >= PWR1_MA)
            || (n_pwr2 >= 2'h2)
            || ((ph1_ma >= PWR3_MA) && (ph2_ma >= PWR3_MA) && (ph3_ma >= PWR3_MA));
        reset_ok = aux_supply ? ((ph1_ma > PH5_MA) || (ph2_ma > PH5_MA) || (ph3_ma > PH5_MA))
            && (earth_ma > EF2_MA) : cur_pwr;
        over_pick = (ph1_ma > pickup) || (ph2_ma > pickup) || (ph3_ma > pickup);
        no_cur = (ph1_ma == 16'h0) && (ph2_ma == 16'h0) && (ph3_ma == 16'h0);
        test_cur = (ph1_ma >= TEST_MA) || (ph2_ma >= TEST_MA) || (ph3_ma >= TEST_MA);
    end

    always_comb
    begin
        trip_req = !prot_inhibit && (
            (fast_trip_in && (ctrl[C_FAST] ? over_pick : cur_pwr))
            || (oc_timeout && !(block_in && ctrl[C_BLK]))
            || (sc_timeout && !(block_in && ctrl[C_BLK+1]))
            || (efh_timeout && !(block_in && ctrl[C_BLK+3]))
            || (ef_timeout && !(block_in && ctrl[C_BLK+2]) && !ctrl[C_EFALM]));
        auto_rst = ctrl[C_AUTO] && reset_ok && (since >= AUTO_T);
        clear = man_done || sw_rst || ext_reset_in || auto_rst;
    end

    // ms time base and time since the last trip
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ms_cnt <= '0;
            since  <= AUTO_T;
        end
        else
        begin
            if (tick)
                ms_cnt <= ms_cnt + TW'(1);
            if (trip_req)
                since <= '0;
            else if (tick && since != AUTO_T)
                since <= since + TW'(1);
        end
    end

    // trip latch and indicator; a trip wins over any clear request, aresetn wins over a trip
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            relay1   <= 1'b0;
            led_on   <= 1'b0;
            ef_alarm <= 1'b0;
        end
        else
        begin
            ef_alarm <= ef_timeout && ctrl[C_EFALM] && !prot_inhibit;
            if (trip_req)
            begin
                relay1 <= 1'b1;
                led_on <= ctrl[C_LED];
            end
            else if (clear)
            begin
                relay1 <= 1'b0;
                led_on <= 1'b0;
            end
        end
    end

    always_comb
    begin
        next_tst = tst;
        unique case (tst)
            T_IDLE:   if (test_req && !aux_supply && no_cur) next_tst = T_WAIT;
            T_WAIT:   if (test_cur) next_tst = T_PULSE;
                      else if (tick && tcnt == WAIT - TW'(1)) next_tst = T_IDLE;
            T_PULSE:  if (!test_cur) next_tst = T_STOP;
                      else if (tick && tcnt == PULSE_T - TW'(1)) next_tst = T_PAUSE1;
            T_PAUSE1: if (tick && tcnt == PAUSE_T - TW'(1)) next_tst = T_SELF;
            T_SELF:   if (tick && tcnt == SELF_T - TW'(1)) next_tst = T_PAUSE2;
            T_PAUSE2: if (tick && tcnt == PAUSE_T - TW'(1)) next_tst = T_PROMPT;
            T_PROMPT: if (key_select) next_tst = T_REMOVE;
            T_REMOVE: if (no_cur) next_tst = T_IDLE;
            T_STOP:   if (no_cur) next_tst = T_IDLE;
            default:  next_tst = T_IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tst  <= T_IDLE;
            tcnt <= '0;
        end
        else
        begin
            tst <= next_tst;
            if (next_tst != tst)
                tcnt <= '0;
            else if (tick)
                tcnt <= tcnt + TW'(1);
        end
    end

    // test outputs and protection drive
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            trip_pulse     <= 1'b0;
            flag_ind       <= 1'b0;
            alarm_relay    <= 1'b0;
            selftest_relay <= 1'b0;
            prot_inhibit   <= 1'b0;
            trip_led       <= 1'b0;
            fault_clear    <= 1'b0;
        end
        else
        begin
            prot_inhibit   <= next_tst != T_IDLE;
            flag_ind       <= next_tst == T_PULSE;
            trip_pulse     <= next_tst == T_PULSE || trip_req;
            selftest_relay <= next_tst == T_SELF;
            if (next_tst == T_PULSE)
                alarm_relay <= 1'b1;
            else if (next_tst == T_IDLE || next_tst == T_REMOVE)
                alarm_relay <= 1'b0;
            trip_led <= (next_tst == T_PROMPT || (led_on && !clear && tst == T_IDLE))
                && ms_cnt[BLINK_BIT];
            fault_clear <= fm_done;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            msg <= M_NONE;
        else if (tst == T_WAIT)
            msg <= M_WAIT;
        else if (tst == T_PULSE || tst == T_PAUSE1 || tst == T_SELF || tst == T_PAUSE2)
            msg <= M_RUN;
        else if (tst == T_PROMPT)
            msg <= M_PRESS;
        else if (tst == T_REMOVE)
            msg <= M_REMOVE;
        else if (tst == T_STOP)
            msg <= M_STOP;
        else if (ext_reset_in)
            msg <= M_EXT;
        else if (msg == M_WAIT)
            msg <= M_SET;
        else if (man_done || sw_rst)
            msg <= M_NONE;
        else if (relay1 && !(ctrl[C_AUTO] && cur_pwr))
            msg <= M_TRIP;
        else if (ctrl[C_AUTO] && cur_pwr)
            msg <= M_DATE;
        else if (msg == M_EXT)
            msg <= M_NONE;
    end

    // AXI4-Lite write channel
    assign wr_do = aw_hold && w_hold && !s_axi_bvalid;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold       <= 1'b0;
            w_hold        <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OK;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0;
            w_strb        <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold       <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_do)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr == REG_CTRL || aw_addr == REG_PICK
                    || aw_addr == REG_TEST || aw_addr == REG_CMD) ? RESP_OK : RESP_DEC;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                aw_hold       <= 1'b0;
                w_hold        <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // software-written settings and one-cycle commands
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl     <= CTRL_RST;
            pickup   <= PICK_RST;
            test_req <= 1'b0;
            sw_rst   <= 1'b0;
        end
        else
        begin
            test_req <= wr_do && aw_addr == REG_TEST && (&w_strb[1:0])
                && w_data[15:0] == PASS_DEF;
            sw_rst   <= wr_do && aw_addr == REG_CMD && w_strb[0] && w_data[0];
            if (wr_do && aw_addr == REG_CTRL && w_strb[0])
                ctrl <= w_data[7:0];
            if (wr_do && aw_addr == REG_PICK && w_strb[0])
                pickup[7:0] <= w_data[7:0];
            if (wr_do && aw_addr == REG_PICK && w_strb[1])
                pickup[15:8] <= w_data[15:8];
        end
    end

    // AXI4-Lite read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= RESP_OK;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= RESP_OK;
            unique case (s_axi_araddr)
                REG_CTRL: s_axi_rdata <= {24'h0, ctrl};
                REG_PICK: s_axi_rdata <= {16'h0, pickup};
                REG_TEST: s_axi_rdata <= 32'h0;
                REG_CMD:  s_axi_rdata <= 32'h0;
                REG_STAT: s_axi_rdata <= {21'h0, msg, tst, relay1, led_on, prot_inhibit};
                default:
                begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= RESP_DEC;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    a_fast_imm: assert property (@(posedge aclk) disable iff (!aresetn)
        !ctrl[C_FAST] && fast_trip_in && cur_pwr && !prot_inhibit |=> relay1 && trip_pulse)
        else $error("immediate fast trip missed");
    a_fast_pick: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl[C_FAST] && fast_trip_in && over_pick && !prot_inhibit |=> relay1)
        else $error("after-pickup fast trip missed");
    a_auto_wait: assert property (@(posedge aclk) disable iff (!aresetn)
        relay1 && since < AUTO_T && !man_done && !sw_rst && !ext_reset_in |=> relay1)
        else $error("auto reset before delay");
    a_ext_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        ext_reset_in && !trip_req |=> !relay1 && !led_on)
        else $error("external reset did not clear");
    a_test_tmo: assert property (@(posedge aclk) disable iff (!aresetn)
        tst == T_WAIT && !test_cur && tick && tcnt == WAIT - TW'(1)
        |=> tst == T_IDLE ##1 msg == M_SET)
        else $error("test timeout not taken");
    a_inhibit: assert property (@(posedge aclk) disable iff (!aresetn)
        tst != T_IDLE && !relay1 |=> !relay1)
        else $error("trip during relay test");
    a_alarm_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(flag_ind) && tst == T_PAUSE1 |-> alarm_relay && !trip_pulse)
        else $error("alarm dropped after pulse");
    a_sel_drop: assert property (@(posedge aclk) disable iff (!aresetn)
        tst == T_PROMPT && key_select |=> tst == T_REMOVE ##1 !alarm_relay && !selftest_relay)
        else $error("select did not drop relays");
    a_test_stop: assert property (@(posedge aclk) disable iff (!aresetn)
        tst == T_PULSE && !test_cur |=> tst == T_STOP ##1 msg == M_STOP)
        else $error("low test current not stopped");
endmodule

//--- logic/prt_pkg.sv
// shared constants and types of the relay trip, reset and test logic
package prt_pkg;
    localparam int unsigned CLK_HZ   = 50_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned CYC_MS   = CLK_HZ / MS_PER_S;
    localparam int unsigned TW       = 16;
    // times in their own units, then in millisecond ticks
    localparam int unsigned HOLD_S   = 3;
    localparam int unsigned AUTO_S   = 3;
    localparam int unsigned WAIT_S   = 30;
    localparam int unsigned PAUSE_S  = 1;
    localparam int unsigned SELF_S   = 1;
    localparam int unsigned PULSE_MS = 150;
    localparam logic [TW-1:0] HOLD_T  = TW'(HOLD_S * MS_PER_S);
    localparam logic [TW-1:0] AUTO_T  = TW'(AUTO_S * MS_PER_S);
    localparam logic [TW-1:0] WAIT_T  = TW'(WAIT_S * MS_PER_S);
    localparam logic [TW-1:0] PAUSE_T = TW'(PAUSE_S * MS_PER_S);
    localparam logic [TW-1:0] SELF_T  = TW'(SELF_S * MS_PER_S);
    localparam logic [TW-1:0] PULSE_T = TW'(PULSE_MS);
    localparam int unsigned BLINK_BIT = 8;
    // currents in mA, fundamental magnitude
    localparam logic [15:0] PWR1_MA  = 16'h015E;
    localparam logic [15:0] PWR2_MA  = 16'h00DC;
    localparam logic [15:0] PWR3_MA  = 16'h00AA;
    localparam logic [15:0] PH5_MA   = 16'h0032;
    localparam logic [15:0] EF2_MA   = 16'h0014;
    localparam logic [15:0] TEST_MA  = 16'h03E8;
    localparam logic [15:0] PICK_RST = 16'h01F4;
    // register byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_PICK = 8'h04;
    localparam logic [7:0] REG_TEST = 8'h08;
    localparam logic [7:0] REG_CMD  = 8'h0C;
    localparam logic [7:0] REG_STAT = 8'h10;
    // control field positions
    localparam int unsigned C_FAST  = 0;
    localparam int unsigned C_AUTO  = 1;
    localparam int unsigned C_LED   = 2;
    localparam int unsigned C_EFALM = 3;
    localparam int unsigned C_BLK   = 4;
    localparam logic [7:0] CTRL_RST = 8'h04;
    localparam logic [15:0] PASS_DEF = 16'h1234; // arbitrary
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_DEC = 2'h3;
    typedef enum logic [3:0] {
        T_IDLE = 4'h0, T_WAIT = 4'h1, T_PULSE = 4'h2, T_PAUSE1 = 4'h3,
        T_SELF = 4'h4, T_PAUSE2 = 4'h5, T_PROMPT = 4'h6, T_REMOVE = 4'h7,
        T_STOP = 4'h8
    } prt_test_t;
    typedef enum logic [3:0] {
        M_NONE = 4'h0, M_DATE = 4'h1, M_EXT = 4'h2, M_SET = 4'h3, M_RUN = 4'h4,
        M_PRESS = 4'h5, M_REMOVE = 4'h6, M_STOP = 4'h7, M_TRIP = 4'h8,
        M_WAIT = 4'h9
    } prt_msg_t;
endpackage

//--- logic/prt_tick.sv
// free-running millisecond tick from the system clock
`timescale 1ns/1ps
module prt_tick #(
    parameter int unsigned DIV = 50000
) (
    input  wire logic aclk,    // system clock
    input  wire logic aresetn, // sync reset, low
    output logic      tick     // one-cycle pulse per ms
);
    logic [31:0] cnt;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt  <= 32'h0;
            tick <= 1'b0;
        end
        else if (cnt == 32'(DIV - 1))
        begin
            cnt  <= 32'h0;
            tick <= 1'b1;
        end
        else
        begin
            cnt  <= cnt + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule

//--- logic/prt_hold.sv
// key hold timer: one pulse once a condition has held for HOLD ticks
`timescale 1ns/1ps
module prt_hold
    import prt_pkg::*;
#(
    parameter logic [TW-1:0] HOLD = HOLD_T
) (
    input  wire logic aclk,    // system clock
    input  wire logic aresetn, // sync reset, low
    input  wire logic tick,    // ms tick
    input  wire logic cond,    // keys held
    output logic      done     // one-cycle pulse
);
    logic [TW-1:0] cnt;
    logic          fired;

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !cond)
        begin
            cnt   <= '0;
            fired <= 1'b0;
            done  <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (tick && !fired)
            begin
                if (cnt == HOLD - TW'(1))
                begin
                    fired <= 1'b1;
                    done  <= 1'b1;
                end
                cnt <= cnt + TW'(1);
            end
        end
    end
endmodule

//--- testbench/prt_ct_model.sv
// current transformer stand-in: feeds fundamental magnitudes to the relay
`timescale 1ns/1ps
module prt_ct_model (
    input  wire logic        aclk, // system clock
    input  wire logic [15:0] cur,  // wanted phase 1 current, mA
    output logic      [15:0] ph1,  // phase 1 magnitude
    output logic      [15:0] ph2,  // phase 2 magnitude
    output logic      [15:0] ph3   // phase 3 magnitude
);
    // only phase 1 carries current; all zero means battery operation
    always_ff @(posedge aclk)
    begin
        ph1 <= cur;
        ph2 <= 16'h0000;
        ph3 <= 16'h0000;
    end
endmodule

//--- testbench/tb_top.sv
// self-checking bench of the relay trip, reset and test logic
`timescale 1ns/1ps
module tb_top;
    import prt_pkg::*;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic awr, wrd, bv, arr, rv, rl1, pin;
    logic [1:0] bresp, rresp, r;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rdt, d, seed = 32'hDC84;
    logic [15:0] cur = 0, em = 0, p1, p2, p3;
    logic ft = 0, blk = 0, ext = 0, oc = 0, dsp = 0, ksel = 0;
    logic aux = 0, km = 0, ef = 0, tp, al, fl, st, efa, fc;
    logic [3:0] ws = 4'hF;
    prt_msg_t msg;
    int num_errors = 0, total_checks = 0, n, j, k;
    prt_ct_model prt_ct_model_i (.aclk(aclk), .cur(cur), .ph1(p1), .ph2(p2), .ph3(p3));
    prt_top #(.DIV(10), .HOLD(16'h0005), .WAIT(16'h0014)) prt_top_i (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(bresp),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
        .s_axi_rready(rre), .s_axi_rdata(rdt), .s_axi_rresp(rresp), .ph1_ma(p1),
        .ph2_ma(p2), .ph3_ma(p3), .earth_ma(em), .aux_supply(aux),
        .fast_trip_in(ft), .block_in(blk), .ext_reset_in(ext), .oc_timeout(oc),
        .sc_timeout(1'b0), .ef_timeout(ef), .efh_timeout(1'b0), .display_on(dsp),
        .key_select(ksel), .key_minus(km), .trip_pulse(tp), .relay1(rl1), .trip_led(),
        .alarm_relay(al), .flag_ind(fl), .selftest_relay(st), .ef_alarm(efa),
        .prot_inhibit(pin), .fault_clear(fc), .msg(msg));
    initial
    begin
        forever #10 aclk = ~aclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task timeout;
        num_errors++;
        $display("[FAIL] wait bound used up");
        tally_and_finish();
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awa <= a;
        wd <= v;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        for (n = 0; n < 50 && bv !== 1'b1; n++)
        begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
        end
        if (n >= 50) timeout();
        bre <= 1'b0;
        r = bresp;
    endtask
    task rdr(input logic [7:0] a);
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        for (n = 0; n < 50 && rv !== 1'b1; n++)
        begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
        end
        if (n >= 50) timeout();
        rre <= 1'b0;
        d = rdt;
        r = rresp;
    endtask
    task wrel(input logic e);
        for (n = 0; n < 300 && rl1 !== e; n++) @(posedge aclk);
        if (n >= 300) timeout();
    endtask
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdr(REG_CTRL);
        chk("ctrl reset", d, 32'h4);
        rdr(8'h40);
        chk("unmapped resp", 32'(r), 32'(RESP_DEC));
        $display("register test done");
        wr(REG_CTRL, 32'h14);
        blk <= 1'b1;
        oc <= 1'b1;
        repeat (5) @(posedge aclk);
        chk("blocked relay", 32'(rl1), 32'h0);
        oc <= 1'b0;
        blk <= 1'b0;
        seed = xs(seed);
        cur <= 16'(350 + seed % 500);
        ft <= 1'b1;
        wrel(1'b1);
        chk("fast trip", 32'(tp), 32'h1);
        ft <= 1'b0;
        dsp <= 1'b1;
        ksel <= 1'b1;
        repeat (20) @(posedge aclk);
        chk("hold early", 32'(rl1), 32'h1);
        wrel(1'b0);
        chk("manual reset", 32'(rl1), 32'h0);
        ksel <= 1'b0;
        oc <= 1'b1;
        wrel(1'b1);
        oc <= 1'b0;
        wr(REG_CMD, 32'h1);
        repeat (2) @(posedge aclk);
        chk("serial reset", 32'(rl1), 32'h0);
        oc <= 1'b1;
        wrel(1'b1);
        oc <= 1'b0;
        ext <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("ext relay", 32'(rl1), 32'h0);
        chk("ext msg", 32'(msg), 32'(M_EXT));
        ext <= 1'b0;
        oc <= 1'b1;
        wrel(1'b1);
        oc <= 1'b0;
        km <= 1'b1;
        ksel <= 1'b1;
        k = 0;
        repeat (100)
        begin
            @(posedge aclk);
            k += fc;
        end
        chk("fmem clear", k, 1);
        km <= 1'b0;
        ksel <= 1'b0;
        aux <= 1'b1;
        em <= 16'h0015;
        wr(REG_CTRL, 32'hE);
        ef <= 1'b1;
        repeat (2) @(posedge aclk);
        chk("ef alarm", 32'(efa), 32'h1);
        ef <= 1'b0;
        repeat (20000) @(posedge aclk);
        chk("auto early", 32'(rl1), 32'h1);
        for (n = 0; n < 12000 && rl1 !== 1'b0; n++) @(posedge aclk);
        if (n >= 12000) timeout();
        chk("auto msg", 32'(msg), 32'(M_DATE));
        aux <= 1'b0;
        cur <= 16'h0000;
        dsp <= 1'b0;
        repeat (3) @(posedge aclk);
        wr(REG_TEST, 32'(PASS_DEF));
        repeat (3) @(posedge aclk);
        chk("test inhibit", 32'(pin), 32'h1);
        for (n = 0; n < 400 && pin !== 1'b0; n++) @(posedge aclk);
        if (n >= 400) timeout();
        @(posedge aclk);
        chk("test timeout msg", 32'(msg), 32'(M_SET));
        ws <= 4'h3;
        wr(REG_TEST, 32'(PASS_DEF));
        cur <= TEST_MA;
        k = 0;
        j = 0;
        for (n = 0; n < 40000 && msg !== M_PRESS; n++)
        begin
            @(posedge aclk);
            k += fl & tp & al;
            j += st;
        end
        if (n >= 40000) timeout();
        chk("pulse ms", (k + 9) / 10, PULSE_MS);
        chk("self ms", (j + 9) / 10, SELF_S * MS_PER_S);
        chk("alarm held", 32'(al), 32'h1);
        ksel <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("select drop", 32'(al | st), 32'h0);
        chk("remove msg", 32'(msg), 32'(M_REMOVE));
        ksel <= 1'b0;
        cur <= 16'h0000;
        repeat (4) @(posedge aclk);
        chk("test end", 32'(pin), 32'h0);
        $display("trip and reset tests done");
        tally_and_finish();
    end
endmodule
